// ### edi_rx_defect_irq.sv
// Receive E3 defect interrupt controller with APB registers
// Functional notes
// - Enabled defect change drives irq low
// - Loss-of-signal change sets status bit 1
// - No automatic far-end failure indication here
// - Out-of-frame change raises on declare, clear
// - Four consecutive errored frames declare out-of-frame
// - In-frame entry clears out-of-frame
// - Enable bit 3 gates out-of-frame source
// - Enable bit one enables, zero disables
// - Out-of-frame change sets status bit 3
// - Loss-of-frame change raises on declare, clear
// - Loss-of-frame after 1 or 3 ms window
// - Return to in-frame clears loss-of-frame
// - Enable bit 1 gates signal-loss source
// - Enable bit 2 gates loss-of-frame source
// - Block enable bit 7 gates irq output
// - Loss-of-signal from 32 zeros or line input
`timescale 1ns/1ns
`default_nettype none
module edi_rx_defect_irq
#(
  parameter int unsigned LOF_SHORT_CYCLES = edi_pkg::LOF_SHORT_CYC,
  parameter int unsigned LOF_LONG_CYCLES = edi_pkg::LOF_LONG_CYC
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framer and line events
  input wire edi_pkg::edi_frame_ev_t frame_i,
  input wire edi_pkg::edi_line_t line_i,
  // Interrupt request, active low
  output logic irq_n
);
  import edi_pkg::*;

  edi_align_t align_reg;
  logic [2:0] err_cnt_reg;
  logic [LOF_CNT_W-1:0] lof_cnt_reg;
  logic [LOF_CNT_W-1:0] lof_limit;
  logic frame_lost_state;
  logic frame_slip_state;
  logic signal_lost_state;
  logic [3:1] prev_reg;
  logic [3:1] cur_state;
  logic [3:1] chg;
  logic int_los_en_reg;
  logic blk_en_reg;
  logic frame_loss_window_select;
  logic [3:1] src_en_reg;
  logic [3:1] status_reg;
  logic [3:1] status_next;
  logic [3:1] clear_mask;
  logic setup;
  logic access_done;
  logic addr_hit;
  logic [5:0] idx;
  logic [31:0] rd_mux;

  // ----------------------------------------
  // Loss-of-signal detection
  // ----------------------------------------
  edi_los_detect edi_los_detect_i
  (
    .pclk(pclk),
    .presetn(presetn),
    .internal_signal_loss_detect(int_los_en_reg),
    .line_i(line_i),
    .signal_lost_o(signal_lost_state)
  );

  // ----------------------------------------
  // Frame alignment state machine
  // ----------------------------------------
  assign lof_limit = frame_loss_window_select ? LOF_CNT_W'(LOF_LONG_CYCLES)
                                              : LOF_CNT_W'(LOF_SHORT_CYCLES);
  assign frame_slip_state = (align_reg != ALIGN_IN_FRAME);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      align_reg <= ALIGN_OUT;
      err_cnt_reg <= 3'h0;
    end
    else
    begin
      case (align_reg)
        ALIGN_IN_FRAME:
        begin
          if (frame_i.frame_tick && frame_i.fas_error)
          begin
            if (err_cnt_reg == OOF_ERR_FRAMES - 3'h1)
            begin
              align_reg <= ALIGN_OUT;
              err_cnt_reg <= 3'h0;
            end
            else
              err_cnt_reg <= err_cnt_reg + 3'h1;
          end
          else if (frame_i.frame_tick)
            err_cnt_reg <= 3'h0;
        end
        ALIGN_OUT:
        begin
          if (frame_i.fas_found)
            align_reg <= ALIGN_VERIFY;
          else if (frame_i.frame_tick && !frame_i.fas_error)
            align_reg <= ALIGN_IN_FRAME;
        end
        ALIGN_VERIFY:
        begin
          if (frame_i.frame_tick && !frame_i.fas_error)
            align_reg <= ALIGN_IN_FRAME;
          else if (frame_i.frame_tick)
            align_reg <= ALIGN_OUT;
        end
        default:
          align_reg <= ALIGN_OUT;
      endcase
    end
  end

  // ----------------------------------------
  // Loss-of-frame window timer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lof_cnt_reg <= '0;
      frame_lost_state <= 1'b1;
    end
    else if (!frame_slip_state)
    begin
      lof_cnt_reg <= '0;
      frame_lost_state <= 1'b0;
    end
    else if (!frame_lost_state)
    begin
      if (lof_cnt_reg >= lof_limit - LOF_CNT_W'(1))
        frame_lost_state <= 1'b1;
      else
        lof_cnt_reg <= lof_cnt_reg + LOF_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Change detection and status
  // ----------------------------------------
  assign cur_state = {frame_slip_state, frame_lost_state, signal_lost_state};
  assign chg = cur_state ^ prev_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_reg <= 3'b110;
    else
      prev_reg <= cur_state;
  end

  // Read clears only the bits the host has seen; a new event wins
  assign clear_mask = (access_done && !pwrite && idx == IDX_IRQ_STATUS) ? prdata[3:1] : 3'h0;
  assign status_next = (status_reg & ~clear_mask) | (chg & src_en_reg);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= RST_SRC_STATUS;
    else
      status_reg <= status_next;
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_n <= 1'b1;
    else
      irq_n <= !(blk_en_reg && |(status_reg & src_en_reg));
  end

  // ----------------------------------------
  // APB register access
  // ----------------------------------------
  assign idx = paddr[7:2];
  assign setup = psel && !penable;
  assign access_done = psel && penable && pready;
  assign addr_hit = (paddr[1:0] == 2'h0) &&
    (idx == IDX_LINE_CFG || idx == IDX_BLK_IRQ_EN || idx == IDX_DEFECT_STATE ||
     idx == IDX_IRQ_ENABLE || idx == IDX_IRQ_STATUS);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_LINE_CFG: rd_mux[BIT_INT_LOS_EN] = int_los_en_reg;
      IDX_BLK_IRQ_EN: rd_mux[BIT_BLK_RX_EN] = blk_en_reg;
      IDX_DEFECT_STATE:
      begin
        rd_mux[BIT_WIN_SEL] = frame_loss_window_select;
        rd_mux[BIT_LOF_STATE] = frame_lost_state;
        rd_mux[BIT_OOF_STATE] = frame_slip_state;
        rd_mux[BIT_LOS_STATE] = signal_lost_state;
      end
      IDX_IRQ_ENABLE: rd_mux[3:1] = src_en_reg;
      IDX_IRQ_STATUS: rd_mux[3:1] = status_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (paddr[1:0] != 2'h0)
      rd_mux = 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (setup)
    begin
      pready <= 1'b1;
      pslverr <= !addr_hit;
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_los_en_reg <= RST_INT_LOS_EN;
      blk_en_reg <= RST_BLK_RX_EN;
      frame_loss_window_select <= RST_WIN_SEL;
      src_en_reg <= RST_SRC_EN;
    end
    else if (access_done && pwrite && addr_hit)
    begin
      case (idx)
        IDX_LINE_CFG: int_los_en_reg <= pwdata[BIT_INT_LOS_EN];
        IDX_BLK_IRQ_EN: blk_en_reg <= pwdata[BIT_BLK_RX_EN];
        IDX_DEFECT_STATE: frame_loss_window_select <= pwdata[BIT_WIN_SEL];
        IDX_IRQ_ENABLE: src_en_reg <= pwdata[3:1];
        default: src_en_reg <= src_en_reg;
      endcase
    end
  end

  // The far-end failure indicator is left to host software

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_irq_assert_low: assert property (@(posedge pclk) disable iff (!presetn)
    (blk_en_reg && |(status_reg & src_en_reg)) |=> !irq_n)
    else $error("irq not low with enabled pending status");
  a_irq_block_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !blk_en_reg |=> irq_n)
    else $error("irq low while block enable is off");
  a_irq_release_high: assert property (@(posedge pclk) disable iff (!presetn)
    (status_reg & src_en_reg) == 3'h0 |=> irq_n)
    else $error("irq low with nothing pending");
  a_los_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    (chg[BIT_SRC_LOS] && src_en_reg[BIT_SRC_LOS]) |=> status_reg[BIT_SRC_LOS])
    else $error("signal loss change did not set status");
  a_oof_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_slip_state != $past(frame_slip_state) && src_en_reg[BIT_SRC_OOF])
      |=> status_reg[BIT_SRC_OOF])
    else $error("out-of-frame change did not set status");
  a_lof_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    (chg[BIT_SRC_LOF] && src_en_reg[BIT_SRC_LOF]) |=> status_reg[BIT_SRC_LOF])
    else $error("loss-of-frame change did not set status");
  a_src_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (!src_en_reg[BIT_SRC_OOF] && !status_reg[BIT_SRC_OOF]) |=> !status_reg[BIT_SRC_OOF])
    else $error("disabled source set its status");
  a_oof_declare_four: assert property (@(posedge pclk) disable iff (!presetn)
    (align_reg == ALIGN_IN_FRAME && frame_i.frame_tick && frame_i.fas_error &&
     err_cnt_reg == 3'h3) |=> frame_slip_state)
    else $error("out-of-frame not declared after four errored frames");
  a_verify_to_frame: assert property (@(posedge pclk) disable iff (!presetn)
    (align_reg == ALIGN_VERIFY && frame_i.frame_tick && !frame_i.fas_error)
      |=> !frame_slip_state ##1 !frame_lost_state)
    else $error("verification pass did not reach in-frame");
  a_lof_window_end: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_slip_state && !frame_lost_state && lof_cnt_reg == lof_limit - LOF_CNT_W'(1))
      |=> frame_lost_state || !frame_slip_state)
    else $error("loss-of-frame not declared at window end");
  a_status_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clear_mask != 3'h0 && chg == 3'h0) |=> (status_reg & $past(clear_mask)) == 3'h0)
    else $error("status bits not cleared by read");
  a_status_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && idx == IDX_IRQ_STATUS) |=> prdata[31:4] == 28'h0 && !prdata[0])
    else $error("reserved status bits not zero");

  c_oof_declared: cover property (@(posedge pclk) disable iff (!presetn)
    !frame_slip_state ##1 frame_slip_state);
  c_lof_declared: cover property (@(posedge pclk) disable iff (!presetn)
    !frame_lost_state ##1 frame_lost_state);
  c_irq_low: cover property (@(posedge pclk) disable iff (!presetn) irq_n ##1 !irq_n);
  c_status_read: cover property (@(posedge pclk) disable iff (!presetn) clear_mask != 3'h0);

endmodule : edi_rx_defect_irq
`default_nettype wire

// ### edi_pkg.sv
// Shared constants and types for the receive E3 defect interrupt block
package edi_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_LINE_CFG = 6'h00;
  localparam logic [5:0] IDX_BLK_IRQ_EN = 6'h04;
  localparam logic [5:0] IDX_DEFECT_STATE = 6'h11;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned BIT_INT_LOS_EN = 5;
  localparam int unsigned BIT_BLK_RX_EN = 7;
  localparam int unsigned BIT_WIN_SEL = 7;
  localparam int unsigned BIT_LOF_STATE = 6;
  localparam int unsigned BIT_OOF_STATE = 5;
  localparam int unsigned BIT_LOS_STATE = 4;
  localparam int unsigned BIT_SRC_OOF = 3;
  localparam int unsigned BIT_SRC_LOF = 2;
  localparam int unsigned BIT_SRC_LOS = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_INT_LOS_EN = 1'b0;
  localparam logic RST_BLK_RX_EN = 1'b0;
  localparam logic RST_WIN_SEL = 1'b0;
  localparam logic [2:0] RST_SRC_EN = 3'h0;
  localparam logic [2:0] RST_SRC_STATUS = 3'h0;

  // ----------------------------------------
  // Timing and counts
  // ----------------------------------------
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned LOF_SHORT_MS = 1;
  localparam int unsigned LOF_LONG_MS = 3;
  localparam int unsigned LOF_SHORT_CYC = LOF_SHORT_MS * CLK_KHZ;
  localparam int unsigned LOF_LONG_CYC = LOF_LONG_MS * CLK_KHZ;
  localparam int unsigned LOF_CNT_W = 17;
  localparam logic [2:0] OOF_ERR_FRAMES = 3'h4;
  localparam logic [5:0] LOS_ZERO_RUN = 6'h20;
  localparam logic [5:0] LOS_CLEAN_BITS = 6'h20;
  localparam logic [2:0] LOS_BAD_ZERO_RUN = 3'h4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ALIGN_IN_FRAME, ALIGN_OUT, ALIGN_VERIFY} edi_align_t;

  typedef struct packed {
    logic frame_tick;
    logic fas_error;
    logic fas_found;
  } edi_frame_ev_t;

  typedef struct packed {
    logic bit_valid;
    logic pos;
    logic neg;
    logic line_signal_loss_in;
  } edi_line_t;

endpackage : edi_pkg

// ### edi_los_detect.sv
// Loss-of-signal detector on the receive line inputs
`timescale 1ns/1ns
`default_nettype none
module edi_los_detect
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic internal_signal_loss_detect,
  // Line
  input wire edi_pkg::edi_line_t line_i,
  // State
  output logic signal_lost_o
);
  import edi_pkg::*;

  logic [5:0] zero_run_reg;
  logic [5:0] clean_cnt_reg;
  logic int_los_reg;
  logic line_zero;

  assign line_zero = !line_i.pos && !line_i.neg;

  // ----------------------------------------
  // Zero run and clean window counters
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zero_run_reg <= 6'h00;
      clean_cnt_reg <= 6'h00;
      int_los_reg <= 1'b0;
    end
    else if (!internal_signal_loss_detect)
    begin
      zero_run_reg <= 6'h00;
      clean_cnt_reg <= 6'h00;
      int_los_reg <= 1'b0;
    end
    else if (line_i.bit_valid)
    begin
      if (line_zero)
      begin
        if (zero_run_reg != LOS_ZERO_RUN)
          zero_run_reg <= zero_run_reg + 6'h01;
        if (zero_run_reg == LOS_ZERO_RUN - 6'h01)
          int_los_reg <= 1'b1;
      end
      else
        zero_run_reg <= 6'h00;
      if (line_zero && zero_run_reg >= {3'h0, LOS_BAD_ZERO_RUN - 3'h1})
        clean_cnt_reg <= 6'h00;
      else if (clean_cnt_reg == LOS_CLEAN_BITS - 6'h01)
      begin
        clean_cnt_reg <= 6'h00;
        int_los_reg <= 1'b0;
      end
      else
        clean_cnt_reg <= clean_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // Combined loss state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      signal_lost_o <= 1'b0;
    else
      signal_lost_o <= line_i.line_signal_loss_in || int_los_reg;
  end

endmodule : edi_los_detect
`default_nettype wire

// ### edi_host_model.sv
// Host processor model: APB master and interrupt service routine
`timescale 1ns/1ns
`default_nettype none
module edi_host_model
(
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Far-end failure control
  output logic far_end_failure_ind
);
  import edi_pkg::*;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    far_end_failure_ind = 1'b0;
  end

  // One APB transfer; released write data is inverted
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer

  // Service routine: status, then defect state, then far-end indication
  task automatic service(output logic [31:0] st, output logic [31:0] sv);
    logic e;
    xfer(1'b0, {IDX_IRQ_STATUS, 2'b00}, 32'h0, st, e);
    xfer(1'b0, {IDX_DEFECT_STATE, 2'b00}, 32'h0, sv, e);
    far_end_failure_ind <= sv[BIT_LOS_STATE] | sv[BIT_OOF_STATE];
  endtask : service
endmodule : edi_host_model
`default_nettype wire

// ### edi_rx_defect_irq_bench.sv
// Testbench for the receive defect interrupt block
`timescale 1ns/1ns
`default_nettype none
module edi_rx_defect_irq_bench;
  import edi_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_n;
  logic far_end_failure_ind;
  edi_frame_ev_t frame_i = '0;
  edi_line_t line_i = '0;
  int mismatches = 0;
  int compares = 0;

  always #20 pclk = ~pclk;

  edi_rx_defect_irq #(.LOF_SHORT_CYCLES(20), .LOF_LONG_CYCLES(60)) edi_rx_defect_irq_i
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_i(frame_i), .line_i(line_i), .irq_n(irq_n)
  );

  edi_host_model edi_host_model_i
  (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .far_end_failure_ind(far_end_failure_ind)
  );

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    edi_host_model_i.xfer(1'b1, {idx, 2'b00}, d, r, e);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    edi_host_model_i.xfer(1'b0, {idx, 2'b00}, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  // Service and compare status, state and far-end indication
  task automatic svc(input logic [31:0] est, input logic [31:0] esv, input logic ef);
    logic [31:0] st;
    logic [31:0] sv;
    edi_host_model_i.service(st, sv);
    chk(st, est);
    chk(sv, esv);
    @(posedge pclk);
    chk({31'h0, far_end_failure_ind}, {31'h0, ef});
  endtask : svc

  task automatic tick(input logic err, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      frame_i <= '{frame_tick: 1'b1, fas_error: err, fas_found: 1'b0};
      @(posedge pclk);
      frame_i <= '0;
    end
    repeat (4) @(posedge pclk);
  endtask : tick

  task automatic bits(input logic v, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      line_i.bit_valid <= 1'b1;
      line_i.pos <= v;
    end
    @(posedge pclk);
    line_i.bit_valid <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : bits

  task automatic loss(input logic v);
    @(posedge pclk);
    line_i.line_signal_loss_in <= v;
    repeat (4) @(posedge pclk);
  endtask : loss

  initial
  begin
    #400000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_DEFECT_STATE, 32'h60);
    rd(IDX_IRQ_STATUS, 32'h0);
    edi_host_model_i.xfer(1'b0, 8'h3c, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    edi_host_model_i.xfer(1'b0, 8'h51, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h80000000);
    wr(IDX_BLK_IRQ_EN, 32'h80);
    wr(IDX_IRQ_ENABLE, 32'hff);
    rd(IDX_IRQ_ENABLE, 32'h0e);
    wr(IDX_LINE_CFG, 32'h20);
    chk({31'h0, irq_n}, 32'h1);
    tick(1'b0, 1);
    chk({31'h0, irq_n}, 32'h0);
    svc(32'h0c, 32'h0, 1'b0);
    rd(IDX_IRQ_STATUS, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    tick(1'b1, 3);
    rd(IDX_IRQ_STATUS, 32'h0);
    tick(1'b1, 1);
    rd(IDX_IRQ_STATUS, 32'h08);
    repeat (20) @(posedge pclk);
    svc(32'h04, 32'h60, 1'b1);
    @(posedge pclk);
    frame_i.fas_found <= 1'b1;
    @(posedge pclk);
    frame_i <= '0;
    tick(1'b0, 1);
    svc(32'h0c, 32'h0, 1'b0);
    wr(IDX_DEFECT_STATE, 32'h80);
    tick(1'b1, 4);
    repeat (30) @(posedge pclk);
    rd(IDX_DEFECT_STATE, 32'ha0);
    repeat (40) @(posedge pclk);
    rd(IDX_DEFECT_STATE, 32'he0);
    tick(1'b0, 1);
    svc(32'h0c, 32'h80, 1'b0);
    loss(1'b1);
    chk({31'h0, irq_n}, 32'h0);
    svc(32'h02, 32'h90, 1'b1);
    loss(1'b0);
    svc(32'h02, 32'h80, 1'b0);
    bits(1'b0, 31);
    rd(IDX_DEFECT_STATE, 32'h80);
    bits(1'b0, 1);
    rd(IDX_DEFECT_STATE, 32'h90);
    bits(1'b1, 32);
    rd(IDX_DEFECT_STATE, 32'h80);
    rd(IDX_IRQ_STATUS, 32'h02);
    wr(IDX_IRQ_ENABLE, 32'h0c);
    loss(1'b1);
    rd(IDX_IRQ_STATUS, 32'h0);
    chk({31'h0, irq_n}, 32'h1);
    wr(IDX_IRQ_ENABLE, 32'h06);
    tick(1'b1, 4);
    rd(IDX_IRQ_STATUS, 32'h0);
    wr(IDX_IRQ_ENABLE, 32'h0a);
    repeat (60) @(posedge pclk);
    rd(IDX_DEFECT_STATE, 32'hf0);
    tick(1'b0, 1);
    rd(IDX_IRQ_STATUS, 32'h08);
    wr(IDX_BLK_IRQ_EN, 32'h0);
    loss(1'b0);
    chk({31'h0, irq_n}, 32'h1);
    wr(IDX_BLK_IRQ_EN, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_n}, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h02);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_n}, 32'h1);
    end_sim();
  end
endmodule : edi_rx_defect_irq_bench
`default_nettype wire
